// ==== core/dma_queue_map_missed_event.sv ====
// Functional notes
// - Each of 64 channels maps to any queue; reset maps all to queue zero.
// - Requests from queue k go only to transfer controller k.
// - Channel queue codes 0-3 pick queues 0-3; codes 4-7 are reserved.
// - Channel c lives in select register c/8, bits 4*(c mod 8) upward; nibble top reads zero.
// - One register holds eight quick-channel 3-bit queue fields at bit 4n, reset zero.
// - Quick field 0-3 routes to queue 0-3; values 4-7 are reserved.
// - Per-queue 3-bit priority at bits 2-0,6-4,10-8,14-12 drives the paired controller.
// - Priority zero is highest, seven lowest.
// - A second event before the first is serviced sets the missed flag.
// - Manual, chained and external triggers are tracked apart for repeats.
// - A null parameter entry or null request also sets the missed flag.
// - Error interrupt fires on a new flag only if all error flags were clear.
// - Flags 0-31 in the low read-only register, 32-63 in the high one.
// - A flag holds until a one is written to its clear bit; zero does nothing.
module dma_queue_map_missed_event
	import qmap_pkg::*;
#(
	parameter int P_DMA_CH = 64,
	parameter int P_QUEUES = 4
)(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire qmap_pkg::tr_in_t i_tr,
	input wire qmap_pkg::trig_in_t i_trig,
	input wire logic i_other_err,
	output logic [31:0] o_rdata,
	output logic [3:0] o_tc_valid,
	output qmap_pkg::tc_req_t o_tc_req,
	output logic [3:0][2:0] o_tc_priority,
	output logic [63:0] o_missed,
	output logic o_irq
);
	import qmap_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register layout is fixed around these sizes, so other values are refused.

	if (P_DMA_CH != NUM_DMA_CH || P_QUEUES != NUM_QUEUES)
	begin : g_size_check
		$error("dma_queue_map_missed_event: channel or queue count not supported");
	end

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [NUM_QUEUES-1:0] queue_onehot(input logic [QFIELD_W-1:0] code);
		logic [NUM_QUEUES-1:0] sel;
		sel = '0;
		// Reserved codes select no queue, so the request is dropped rather than misrouted.
		if (code <= QCODE_LAST_VALID)
		begin
			sel[code[1:0]] = 1'b1;
		end
		return sel;
	endfunction

	function automatic logic [WORD_W-1:0] pack_fields(input logic [FIELDS_PER_REG-1:0][QFIELD_W-1:0] f);
		logic [WORD_W-1:0] w;
		w = '0;
		for (int j = 0; j < FIELDS_PER_REG; j++)
		begin
			w[j*QFIELD_STRIDE +: QFIELD_W] = f[j];
		end
		return w;
	endfunction

	state_t st_ff;
	state_t nxt_st;
	logic [NUM_DMA_CH-1:0] set_vec;
	logic [NUM_DMA_CH-1:0] clr_vec;
	logic err_evt;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic [FIELDS_PER_REG-1:0][QFIELD_W-1:0] fields;
		logic [QFIELD_W-1:0] code;
		fields = '0;
		code = '0;
		nxt_st = st_ff;
		nxt_st.rdata = '0;
		nxt_st.tc_vld = '0;
		set_vec = '0;
		clr_vec = '0;

		// Register writes.
		if (i_wr)
		begin
			if (i_addr <= ADDR_DMA_QSEL_LAST && i_addr[1:0] == 2'h0)
			begin
				for (int c = 0; c < NUM_DMA_CH; c++)
				begin
					if (c / FIELDS_PER_REG == int'(i_addr[4:2]))
					begin
						nxt_st.dma_q[c] = i_wdata[(c % FIELDS_PER_REG)*QFIELD_STRIDE +: QFIELD_W];
					end
				end
			end
			if (i_addr == ADDR_QUICK_QSEL)
			begin
				for (int q = 0; q < NUM_QUICK_CH; q++)
				begin
					nxt_st.quick_q[q] = i_wdata[q*QFIELD_STRIDE +: QFIELD_W];
				end
			end
			if (i_addr == ADDR_QUEUE_PRI)
			begin
				for (int k = 0; k < NUM_QUEUES; k++)
				begin
					nxt_st.pri[k] = i_wdata[k*QFIELD_STRIDE +: QFIELD_W];
				end
			end
			if (i_addr == ADDR_CLEAR_LOW)
			begin
				clr_vec[WORD_W-1:0] = i_wdata;
			end
			if (i_addr == ADDR_CLEAR_HIGH)
			begin
				clr_vec[NUM_DMA_CH-1:WORD_W] = i_wdata;
			end
			if (i_addr == ADDR_IRQ_MASK)
			begin
				nxt_st.irq_mask = i_wdata[IRQ_BITS-1:0];
			end
		end

		// Register reads; reserved nibble bits and unmapped addresses read zero.
		if (i_rd)
		begin
			if (i_addr <= ADDR_DMA_QSEL_LAST && i_addr[1:0] == 2'h0)
			begin
				for (int j = 0; j < FIELDS_PER_REG; j++)
				begin
					fields[j] = st_ff.dma_q[int'(i_addr[4:2])*FIELDS_PER_REG + j];
				end
				nxt_st.rdata = pack_fields(fields);
			end
			else
			begin
				unique case (i_addr)
					ADDR_QUICK_QSEL: nxt_st.rdata = pack_fields(st_ff.quick_q);
					ADDR_QUEUE_PRI: nxt_st.rdata = pack_fields({{(FIELDS_PER_REG-NUM_QUEUES)*QFIELD_W{1'b0}}, st_ff.pri});
					ADDR_MISSED_LOW: nxt_st.rdata = st_ff.missed[WORD_W-1:0];
					ADDR_MISSED_HIGH: nxt_st.rdata = st_ff.missed[NUM_DMA_CH-1:WORD_W];
					ADDR_IRQ_STATUS: nxt_st.rdata = {{(WORD_W-IRQ_BITS){1'b0}}, st_ff.irq_stat};
					ADDR_IRQ_MASK: nxt_st.rdata = {{(WORD_W-IRQ_BITS){1'b0}}, st_ff.irq_mask};
					default: nxt_st.rdata = RESET_WORD;
				endcase
			end
		end

		// Repeat detection per trigger type; a fresh hit outranks a service in the same cycle.
		for (int t = 0; t < NUM_TRIG_TYPES; t++)
		begin
			set_vec = set_vec | (i_trig.hit[t] & st_ff.pend[t]);
			nxt_st.pend[t] = i_trig.hit[t] | (st_ff.pend[t] & ~i_trig.service);
		end
		set_vec = set_vec | i_trig.null_hit;
		nxt_st.missed = (st_ff.missed & ~clr_vec) | set_vec;

		// Only the first error after a fully clean state raises the error event.
		err_evt = (|set_vec) && (st_ff.missed == '0) && !i_other_err;

		// Sticky status: a read clears it, but an event in the same cycle survives.
		if (i_rd && i_addr == ADDR_IRQ_STATUS)
		begin
			nxt_st.irq_stat = '0;
		end
		nxt_st.irq_stat[IRQ_ERR] = nxt_st.irq_stat[IRQ_ERR] | err_evt;
		nxt_st.irq_stat[IRQ_MISS] = nxt_st.irq_stat[IRQ_MISS] | (|set_vec);
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// Queue k feeds controller k only, so the one-hot queue is the controller strobe.
		if (i_tr.valid)
		begin
			code = i_tr.quick ? st_ff.quick_q[i_tr.chan[2:0]] : st_ff.dma_q[i_tr.chan];
			nxt_st.tc_vld = queue_onehot(code);
			nxt_st.tc_req.quick = i_tr.quick;
			nxt_st.tc_req.chan = i_tr.chan;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			st_ff <= '0;
			st_ff.irq_mask <= IRQ_MASK_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		o_rdata = st_ff.rdata;
		o_tc_valid = st_ff.tc_vld;
		o_tc_req = st_ff.tc_req;
		// Passed through unchanged: zero is the strongest claim on the system bus.
		o_tc_priority = st_ff.pri;
		o_missed = st_ff.missed;
		o_irq = st_ff.irq;
	end

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_manual_twice;
		i_trig.hit[TRIG_MANUAL][5] ##1 !i_trig.service[5] ##1 i_trig.hit[TRIG_MANUAL][5];
	endsequence

	sequence s_chain_after_manual;
		(i_trig.hit[TRIG_MANUAL][5] && !i_trig.hit[TRIG_CHAIN][5] && !i_trig.hit[TRIG_EXT][5] && !i_trig.null_hit[5]
			&& !st_ff.pend[TRIG_MANUAL][5] && !st_ff.pend[TRIG_CHAIN][5] && !st_ff.missed[5])
			##1 (!i_trig.hit[TRIG_MANUAL][5] && !i_trig.hit[TRIG_CHAIN][5] && !i_trig.hit[TRIG_EXT][5]
			&& !i_trig.null_hit[5])
			##1 (i_trig.hit[TRIG_CHAIN][5] && !i_trig.hit[TRIG_MANUAL][5] && !i_trig.hit[TRIG_EXT][5]
			&& !i_trig.null_hit[5]);
	endsequence

	a_reset_queue_zero: assert property ($past(!i_rst_n) |-> st_ff.dma_q == '0 && st_ff.quick_q == '0)
		else $error("queue selects not zero after reset");

	a_route_to_tc: assert property (i_tr.valid && !i_tr.quick && st_ff.dma_q[i_tr.chan] == 3'h2
		|=> o_tc_valid == 4'h4 && o_tc_req.chan == $past(i_tr.chan))
		else $error("request not sent to controller matching its queue");

	a_reserved_code_drop: assert property (i_tr.valid && !i_tr.quick && st_ff.dma_q[i_tr.chan] > 3'h3
		|=> o_tc_valid == 4'h0)
		else $error("reserved queue code produced a request");

	a_select_layout: assert property (i_wr && i_addr == 8'h04 ##1 (!i_wr && !i_rd)
		##1 (i_rd && i_addr == 8'h04 && !i_wr)
		|=> st_ff.dma_q[9] == $past(i_wdata[6:4], 3) && (o_rdata & 32'h8888_8888) == 32'h0000_0000)
		else $error("channel select field misplaced or reserved bit reads one");

	a_quick_route: assert property (i_tr.valid && i_tr.quick && st_ff.quick_q[i_tr.chan[2:0]] == 3'h3
		|=> o_tc_valid == 4'h8 && o_tc_req.quick)
		else $error("quick channel routed to wrong queue");

	a_priority_out: assert property (i_wr && i_addr == ADDR_QUEUE_PRI
		|=> o_tc_priority[3] == $past(i_wdata[14:12]) && o_tc_priority[0] == $past(i_wdata[2:0]))
		else $error("queue priority not presented to controller");

	a_missed_repeat: assert property (s_manual_twice |=> st_ff.missed[5])
		else $error("repeated manual trigger did not set missed flag");

	a_types_separate: assert property (s_chain_after_manual |=> !st_ff.missed[5])
		else $error("different trigger types counted as a repeat");

	a_null_entry: assert property (i_trig.null_hit[40] |=> st_ff.missed[40])
		else $error("null entry did not set missed flag");

	a_first_error_irq: assert property ((|set_vec) && st_ff.missed == '0 && !i_other_err
		|=> st_ff.irq_stat[IRQ_ERR])
		else $error("first error did not raise error event");

	a_no_second_irq: assert property (st_ff.missed != '0 && !(i_rd && i_addr == ADDR_IRQ_STATUS)
		&& !st_ff.irq_stat[IRQ_ERR] |=> !st_ff.irq_stat[IRQ_ERR])
		else $error("error event raised while errors were pending");

	a_high_flags_read: assert property (i_rd && i_addr == ADDR_MISSED_HIGH
		|=> o_rdata == $past(st_ff.missed[63:32]))
		else $error("high missed flags read wrong");

	a_clear_one: assert property (i_wr && i_addr == ADDR_CLEAR_LOW && i_wdata[5] && !set_vec[5]
		|=> !st_ff.missed[5])
		else $error("writing one did not clear missed flag");

	a_clear_zero_hold: assert property (st_ff.missed[5] && !clr_vec[5] |=> st_ff.missed[5])
		else $error("missed flag dropped without a clear");

	a_set_wins: assert property (set_vec[5] && clr_vec[5] |=> st_ff.missed[5])
		else $error("clear beat a simultaneous missed event");

	////////////////////////////////////////////////////////////////////////////////
	// Further checks on the register port, the request lanes and the error path.

	sequence s_status_read_quiet;
		i_rd && i_addr == ADDR_IRQ_STATUS && set_vec == '0;
	endsequence

	sequence s_null_then_idle;
		i_trig.null_hit[40] ##1 !clr_vec[40];
	endsequence

	a_reset_outputs: assert property ($past(!i_rst_n)
		|-> o_missed == '0 && o_tc_valid == 4'h0 && !o_irq)
		else $error("outputs not cleared by reset");

	a_rdata_idle: assert property (!i_rd
		|=> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");

	a_select_reserved: assert property (i_rd && i_addr <= ADDR_QUEUE_PRI
		|=> (o_rdata & 32'h8888_8888) == 32'h0000_0000)
		else $error("reserved nibble bit reads one");

	a_pri_upper_zero: assert property (i_rd && i_addr == ADDR_QUEUE_PRI
		|=> o_rdata[31:15] == 17'h0_0000)
		else $error("upper priority bits read one");

	a_low_flags_read: assert property (i_rd && i_addr == ADDR_MISSED_LOW
		|=> o_rdata == $past(st_ff.missed[31:0]))
		else $error("low missed flags read wrong");

	a_quick_fields: assert property (i_wr && i_addr == ADDR_QUICK_QSEL
		|=> st_ff.quick_q[7] == $past(i_wdata[30:28]) && st_ff.quick_q[0] == $past(i_wdata[2:0]))
		else $error("quick channel field misplaced");

	a_priority_mid: assert property (i_wr && i_addr == ADDR_QUEUE_PRI
		|=> o_tc_priority[1] == $past(i_wdata[6:4]) && o_tc_priority[2] == $past(i_wdata[10:8]))
		else $error("middle queue priorities not presented");

	a_priority_hold: assert property (!(i_wr && i_addr == ADDR_QUEUE_PRI)
		|=> $stable(o_tc_priority))
		else $error("queue priority changed without a write");

	a_lane_onehot: assert property ($onehot0(o_tc_valid)
		)
		else $error("request sent to more than one controller");

	a_lane_idle: assert property (!i_tr.valid
		|=> o_tc_valid == 4'h0)
		else $error("controller strobe without a request");

	a_dma_queue_one: assert property (i_tr.valid && !i_tr.quick && st_ff.dma_q[i_tr.chan] == 3'h1
		|=> o_tc_valid == 4'h2 && !o_tc_req.quick)
		else $error("channel on queue one routed wrong");

	a_quick_queue_zero: assert property (i_tr.valid && i_tr.quick && st_ff.quick_q[i_tr.chan[2:0]] == 3'h0
		|=> o_tc_valid == 4'h1 && o_tc_req.chan == $past(i_tr.chan))
		else $error("quick channel on queue zero routed wrong");

	a_no_spurious_flag: assert property (!st_ff.missed[5] && !set_vec[5]
		|=> !st_ff.missed[5])
		else $error("missed flag set without a cause");

	a_null_sticky: assert property (s_null_then_idle
		|=> st_ff.missed[40])
		else $error("null entry flag did not hold");

	a_clear_high_one: assert property (i_wr && i_addr == ADDR_CLEAR_HIGH && i_wdata[8] && !set_vec[40]
		|=> !st_ff.missed[40])
		else $error("writing one did not clear high missed flag");

	a_status_read_clear: assert property (s_status_read_quiet
		|=> st_ff.irq_stat == '0)
		else $error("status read did not clear events");

	a_other_err_block: assert property ((|set_vec) && i_other_err && !st_ff.irq_stat[IRQ_ERR]
		|=> !st_ff.irq_stat[IRQ_ERR])
		else $error("error event raised while other errors were set");

	a_irq_follows: assert property (st_ff.irq_stat[IRQ_MISS] && st_ff.irq_mask[IRQ_MISS]
		|-> o_irq)
		else $error("unmasked status did not raise interrupt");

endmodule // dma_queue_map_missed_event

// ==== core/qmap_pkg.sv ====
package qmap_pkg;

	localparam int NUM_DMA_CH = 64;
	localparam int NUM_QUICK_CH = 8;
	localparam int NUM_QUEUES = 4;
	localparam int QFIELD_W = 3;
	localparam int QFIELD_STRIDE = 4;
	localparam int FIELDS_PER_REG = 8;
	localparam int WORD_W = 32;
	localparam int NUM_TRIG_TYPES = 3;
	localparam int TRIG_MANUAL = 0;
	localparam int TRIG_CHAIN = 1;
	localparam int TRIG_EXT = 2;

	// Byte addresses on the register port.
	localparam logic [7:0] ADDR_DMA_QSEL_BASE = 8'h00;
	localparam logic [7:0] ADDR_DMA_QSEL_LAST = 8'h1C;
	localparam logic [7:0] ADDR_QUICK_QSEL = 8'h20;
	localparam logic [7:0] ADDR_QUEUE_PRI = 8'h24;
	localparam logic [7:0] ADDR_MISSED_LOW = 8'h28;
	localparam logic [7:0] ADDR_MISSED_HIGH = 8'h2C;
	localparam logic [7:0] ADDR_CLEAR_LOW = 8'h30;
	localparam logic [7:0] ADDR_CLEAR_HIGH = 8'h34;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h38;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h3C;

	localparam logic [2:0] QCODE_LAST_VALID = 3'h3;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam int IRQ_BITS = 2;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_MISS = 1;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 2'h0;

	typedef struct packed {
		logic valid;
		logic quick;
		logic [5:0] chan;
	} tr_in_t;

	typedef struct packed {
		logic quick;
		logic [5:0] chan;
	} tc_req_t;

	typedef struct packed {
		logic [NUM_TRIG_TYPES-1:0][NUM_DMA_CH-1:0] hit;
		logic [NUM_DMA_CH-1:0] service;
		logic [NUM_DMA_CH-1:0] null_hit;
	} trig_in_t;

	typedef struct packed {
		logic [NUM_DMA_CH-1:0][QFIELD_W-1:0] dma_q;
		logic [NUM_QUICK_CH-1:0][QFIELD_W-1:0] quick_q;
		logic [NUM_QUEUES-1:0][QFIELD_W-1:0] pri;
		logic [NUM_DMA_CH-1:0] missed;
		logic [NUM_TRIG_TYPES-1:0][NUM_DMA_CH-1:0] pend;
		logic [IRQ_BITS-1:0] irq_stat;
		logic [IRQ_BITS-1:0] irq_mask;
		logic irq;
		logic [WORD_W-1:0] rdata;
		logic [NUM_QUEUES-1:0] tc_vld;
		tc_req_t tc_req;
	} state_t;

endpackage

// ==== dv/tc_sink_model.sv ====
module tc_sink_model
	import qmap_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_tc_valid,
	input wire qmap_pkg::tc_req_t i_tc_req,
	input wire logic [3:0][2:0] i_tc_priority,
	output logic o_got,
	output logic [11:0] o_seen
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] idx;

	always_comb
	begin
		idx = 2'h0;
		for (int k = 0; k < 4; k++)
			if (i_tc_valid[k])
				idx = 2'(k);
	end

	// Each controller takes only the requests of its own lane, tagged with that lane's priority.
	// Two lanes at once cannot be told apart here, so they report all ones, which only a quick channel 63 request on lane 3 at priority 7 matches.
	always_ff @(posedge i_core_clk)
	begin
		o_got <= i_rst_n && (i_tc_valid != 4'h0);
		o_seen <= $onehot0(i_tc_valid) ? {idx, i_tc_req, i_tc_priority[idx]} : 12'hfff;
	end
endmodule // tc_sink_model

// ==== dv/dma_queue_map_missed_event_tb_top.sv ====
module dma_queue_map_missed_event_tb_top
	import qmap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	tr_in_t i_tr = '0;
	trig_in_t trig = '0;
	logic i_other_err = 1'b0;
	logic [31:0] o_rdata;
	logic [3:0] o_tc_valid;
	tc_req_t o_tc_req;
	logic [3:0][2:0] o_tc_priority;
	logic [63:0] o_missed;
	logic o_irq;
	logic got;
	logic [11:0] seen;
	logic rd_q = 1'b0;
	logic [31:0] qw [10];
	logic [31:0] rdq [$];
	logic [11:0] rq [$];
	int fail_count = 0;
	int num_checks = 0;
	int seed = 54331;

	dma_queue_map_missed_event #(.P_DMA_CH(64), .P_QUEUES(4)) i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tr(i_tr), .i_trig(trig),
		.i_other_err(i_other_err), .o_rdata(o_rdata), .o_tc_valid(o_tc_valid), .o_tc_req(o_tc_req),
		.o_tc_priority(o_tc_priority), .o_missed(o_missed), .o_irq(o_irq));

	tc_sink_model i_sink (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_tc_valid(o_tc_valid),
		.i_tc_req(o_tc_req), .i_tc_priority(o_tc_priority), .o_got(got), .o_seen(seen));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		num_checks++;
		if (seen_v !== exp_v)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Every strobe is followed by an idle cycle so no signal is assigned twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		rdq.push_back(d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask

	task automatic send(input logic quick, input logic [5:0] chan);
		@(posedge i_core_clk);
		i_tr <= {1'b1, quick, chan};
		@(posedge i_core_clk);
		i_tr <= '0;
	endtask

	task automatic pulse(input logic [2:0] h, input logic s, input logic n, input int c);
		@(posedge i_core_clk);
		for (int t = 0; t < 3; t++)
			trig.hit[t][c] <= h[t];
		trig.service[c] <= s;
		trig.null_hit[c] <= n;
		@(posedge i_core_clk);
		trig <= '0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever
			#2.5 i_core_clk = ~i_core_clk;
	end

	// Read data is looked at only in the one cycle after the strobe, when it stands.
	always @(posedge i_core_clk)
	begin
		rd_q <= i_rd;
		if (rd_q)
			check(o_rdata, (rdq.size() != 0) ? rdq.pop_front() : 32'hdead_beef);
		if (got)
			check(32'(seen), (rq.size() != 0) ? 32'(rq.pop_front()) : 32'hffff_ffff);
	end

	initial
	begin
		repeat (5000) @(posedge i_core_clk);
		fail_count++;
		give_verdict();
	end

	initial
	begin
		logic [2:0] q;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		for (int a = 0; a <= 8'h40; a += 4)
			rd(8'(a), RESET_WORD);
		// Reserved bits stay zero on writes; codes stay within the four queues present.
		for (int r = 0; r < 10; r++)
		begin
			qw[r] = $random(seed) & ((r < 9) ? 32'h3333_3333 : 32'h0000_7777);
			wr(8'(4 * r), qw[r]);
			rd(8'(4 * r), qw[r]);
		end
		for (int c = 0; c < 72; c++)
		begin
			q = (c < 64) ? qw[c / 8][4 * (c % 8) +: 3] : qw[8][4 * (c - 64) +: 3];
			rq.push_back({q[1:0], c >= 64, 6'(c % 64), qw[9][4 * q[1:0] +: 3]});
			send(c >= 64, 6'(c % 64));
		end
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		pulse(3'b001, 1'b0, 1'b0, 5);
		pulse(3'b010, 1'b0, 1'b0, 5);
		pulse(3'b100, 1'b0, 1'b0, 5);
		rd(ADDR_MISSED_LOW, 32'h0000_0000);
		pulse(3'b001, 1'b0, 1'b0, 5);
		rd(ADDR_MISSED_LOW, 32'h0000_0020);
		check(o_irq, 1'b1);
		rd(ADDR_IRQ_STATUS, 32'h0000_0003);
		pulse(3'b000, 1'b0, 1'b1, 40);
		rd(ADDR_MISSED_HIGH, 32'h0000_0100);
		check(o_missed[63:32], 32'h0000_0100);
		wr(ADDR_CLEAR_LOW, 32'h0000_0000);
		fork
			wr(ADDR_CLEAR_LOW, 32'h0000_0020);
			pulse(3'b001, 1'b0, 1'b0, 5);
		join
		rd(ADDR_MISSED_LOW, 32'h0000_0020);
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		@(posedge i_core_clk);
		#1;
		check(o_irq, 1'b0);
		rd(ADDR_IRQ_STATUS, 32'h0000_0002);
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		pulse(3'b000, 1'b1, 1'b0, 5);
		wr(ADDR_CLEAR_LOW, 32'h0000_0020);
		wr(ADDR_CLEAR_HIGH, 32'h0000_0100);
		rd(ADDR_MISSED_LOW, 32'h0000_0000);
		rd(ADDR_MISSED_HIGH, 32'h0000_0000);
		check(o_missed[63:32] | o_missed[31:0], 32'h0000_0000);
		i_other_err <= 1'b1;
		pulse(3'b001, 1'b0, 1'b0, 7);
		pulse(3'b000, 1'b1, 1'b0, 7);
		pulse(3'b001, 1'b0, 1'b0, 7);
		rd(ADDR_MISSED_LOW, 32'h0000_0000);
		pulse(3'b001, 1'b0, 1'b0, 7);
		rd(ADDR_IRQ_STATUS, 32'h0000_0002);
		pulse(3'b001, 1'b0, 1'b0, 5);
		pulse(3'b001, 1'b0, 1'b0, 5);
		rd(ADDR_MISSED_LOW, 32'h0000_00a0);
		// A second reset in mid-run must bring every select and flag back to zero.
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(8'h04, RESET_WORD);
		rd(ADDR_MISSED_LOW, RESET_WORD);
		repeat (4) @(posedge i_core_clk);
		check(rq.size(), 0);
		check(rdq.size(), 0);
		give_verdict();
	end
endmodule // dma_queue_map_missed_event_tb_top
